//--- dv/tb_tdc_align.sv
// self-checking bench of the time alignment counters
// assumes tdc_front_model drives the pins, the bench all the rest
`timescale 1ns/10ps
`include "tdc_align_regs.svh"
module tb_tdc_align;
  import tdc_align_pkg::*;
  logic        i_clk, i_rst, i_csr_we, i_pair_mode, i_chan_full;
  logic        i_oldest_valid, i_l1_valid, i_l1_separator;
  logic        i_hit, i_trigger, i_bunch_rst, i_event_rst;
  logic        o_trig_valid, o_search_open, o_match_open, o_reject_old;
  logic        o_chan_valid, o_l1_valid, sticky;
  logic [3:0]  i_csr_addr;
  logic [8:0]  i_l1_occupancy;
  logic [11:0] i_csr_wdata, i_oldest_coarse, o_csr_rdata, o_coarse_time;
  logic [11:0] o_trig_tag, o_trig_event, o_latency, mp, tp, ep, lim, s;
  logic [16:0] i_vernier;
  logic [23:0] o_channel_enable;
  logic [31:0] i_l1_data, seed;
  chan_word_t  o_chan_word, cw;
  l1_word_t    o_l1_word, lw;
  int          err_count, num_checks, cycles, n, m;
  logic [8:0]  occ_tab [8] = '{9'h0fc, 9'h0fd, 9'h0fa, 9'h0fb,
                               9'h0fc, 9'h0fa, 9'h0ff, 9'h064};

  tdc_front_model i_tdc_front_model (.i_clk(i_clk), .o_hit(i_hit),
    .o_trigger(i_trigger), .o_bunch_rst(i_bunch_rst),
    .o_event_rst(i_event_rst));
  tdc_align i_tdc_align (.i_clk(i_clk), .i_rst(i_rst),
    .i_csr_we(i_csr_we), .i_csr_addr(i_csr_addr),
    .i_csr_wdata(i_csr_wdata), .i_bunch_rst(i_bunch_rst),
    .i_event_rst(i_event_rst), .i_trigger(i_trigger), .i_hit(i_hit),
    .i_pair_mode(i_pair_mode), .i_vernier(i_vernier),
    .i_chan_full(i_chan_full), .i_oldest_valid(i_oldest_valid),
    .i_oldest_coarse(i_oldest_coarse), .i_l1_valid(i_l1_valid),
    .i_l1_data(i_l1_data), .i_l1_separator(i_l1_separator),
    .i_l1_occupancy(i_l1_occupancy), .o_csr_rdata(o_csr_rdata),
    .o_coarse_time(o_coarse_time), .o_trig_valid(o_trig_valid),
    .o_trig_tag(o_trig_tag), .o_trig_event(o_trig_event),
    .o_search_open(o_search_open), .o_match_open(o_match_open),
    .o_latency(o_latency), .o_reject_old(o_reject_old),
    .o_chan_valid(o_chan_valid), .o_chan_word(o_chan_word),
    .o_l1_valid(o_l1_valid), .o_l1_word(o_l1_word),
    .o_channel_enable(o_channel_enable));

  // 250 MHz; the run ceiling is far above the few hundred cycles used
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic finish_test();
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [45:0] e, g);
    num_checks++;
    if (e !== g)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask : cyc

  task automatic csr_wr(input logic [3:0] a, input logic [11:0] d);
    @(negedge i_clk);
    {i_csr_we, i_csr_addr, i_csr_wdata} = {1'b1, a, d};
    @(negedge i_clk);
    i_csr_we = 1'b0;
  endtask : csr_wr

  // read data is registered, so it is looked at one cycle later
  task automatic csr_rd(input logic [3:0] a, input logic [11:0] e);
    @(negedge i_clk);
    i_csr_addr = a;
    @(negedge i_clk);
    check("csr_rdata", e, o_csr_rdata);
  endtask : csr_rd

  // bounded wait for one channel word
  task automatic wait_chan();
    n = 0;
    while (o_chan_valid !== 1'b1 && n < 10)
    begin
      cyc(1);
      n++;
    end
    cw = o_chan_word;
    check("chan_valid", 1, o_chan_valid);
  endtask : wait_chan

  // bunch reset held high keeps every counter at its preload
  task automatic bunch(input logic lvl);
    i_tdc_front_model.drive(2, lvl);
    cyc(6);
  endtask : bunch

  initial
  begin
    {i_clk, i_rst, i_csr_we, i_pair_mode, i_chan_full} = 5'h01 << 3;
    {i_oldest_valid, i_l1_valid, i_l1_separator} = 3'h0;
    {i_csr_addr, i_csr_wdata, i_oldest_coarse} = '0;
    {i_vernier, i_l1_data, i_l1_occupancy} = '0;
    {err_count, num_checks, cycles, seed, sticky} = {96'h0, 32'hc4e5, 1'b0};
    cyc(8);
    i_rst = 1'b0;
    check("chan_enable", 24'hffffff, o_channel_enable);
    // reset values, unmapped reads give zero
    for (int a = 1; a < 15; a++)
      csr_rd(a, (a == 8 || a > 12) ? `RST_WRAP : `RST_SPAN);
    csr_wr(4'h9, 12'h5a5);
    csr_rd(4'h9, 12'h000);
    for (int a = 1; a < 9; a++)
    begin
      s = xs();
      csr_wr(a, s);
      csr_rd(a, s);
    end
    {mp, tp} = {xs(), xs()};
    csr_wr(`CSR_MEASURE_PRE, mp);
    csr_wr(`CSR_TAG_PRE, tp);
    cyc(2);
    check("latency", 12'(mp - tp), o_latency);
    s = xs();
    csr_wr(`CSR_EN_HIGH, s);
    csr_wr(`CSR_EN_LOW, ~s);
    check("chan_enable", {s, ~s}, o_channel_enable);
    // roll over near the top, wrap kept above 0x800 plus search span
    csr_wr(`CSR_SEARCH_SPAN, 12'h001);
    csr_wr(`CSR_WRAP, 12'h900);
    csr_wr(`CSR_MEASURE_PRE, 12'h8fe);
    bunch(1);
    check("coarse_load", 12'h8fe, o_coarse_time);
    i_tdc_front_model.drive(2, 0);
    n = 0;
    while (o_coarse_time === 12'h8fe && n < 10)
    begin
      cyc(1);
      n++;
    end
    s = 12'h8ff;
    for (int k = 0; k < 4; k++)
    begin
      check("coarse_step", s, o_coarse_time);
      s = (s == 12'h900) ? 12'h000 : s + 1;
      cyc(1);
    end
    csr_wr(`CSR_MEASURE_PRE, 12'ha00);
    bunch(1);
    check("coarse_clamp", 12'h900, o_coarse_time);
    // reject age with the counters frozen by a held bunch reset
    csr_wr(`CSR_WRAP, 12'hfff);
    {mp, lim} = {xs(), 12'(xs() % 12'hffd + 1)};
    csr_wr(`CSR_MEASURE_PRE, mp);
    csr_wr(`CSR_AGE_PRE, mp - lim);
    csr_wr(`CSR_TAG_PRE, mp - lim + 12'h008);
    cyc(4);
    for (int k = 0; k < 3; k++)
    begin
      {i_oldest_valid, i_oldest_coarse} = {1'b1, 12'(mp - lim - k + 1)};
      cyc(3);
      check("reject_old", k == 2, o_reject_old);
    end
    i_oldest_valid = 1'b0;
    // triggers: tag lag, event number, span lengths
    {mp, tp, ep} = {xs(), xs(), xs()};
    csr_wr(`CSR_MEASURE_PRE, mp);
    csr_wr(`CSR_TAG_PRE, tp);
    csr_wr(`CSR_EVENT_PRE, ep);
    bunch(1);
    bunch(0);
    for (int k = 0; k < 3; k++)
    begin
      s = (k == 0) ? 12'h001 : 12'(xs() % 40 + 1);
      csr_wr(`CSR_SEARCH_SPAN, s);
      csr_wr(`CSR_MATCH_SPAN, s - (k != 0));
      if (k == 2)
        i_tdc_front_model.drive(3, 1);
      cyc(4);
      i_tdc_front_model.drive(3, 0);
      i_tdc_front_model.drive(1, 1);
      n = 0;
      while (o_trig_valid !== 1'b1 && n < 10)
      begin
        cyc(1);
        n++;
      end
      check("trig_event", (k == 2) ? ep : 12'(ep + k), o_trig_event);
      // tag is taken one cycle before coarse time is seen here
      lim = 12'(o_coarse_time - o_trig_tag - (mp - tp));
      check("trig_lag", 12'h001, lim);
      // the first open tick stands already in the trigger cycle
      {n, m} = {32'(o_search_open), 32'(o_match_open)};
      i_tdc_front_model.drive(1, 0);
      for (int c = 0; c < 60; c++)
      begin
        n += (o_search_open === 1'b1);
        m += (o_match_open === 1'b1);
        cyc(1);
      end
      check("search_ticks", s, n);
      check("match_ticks", s - (k != 0), m);
    end
    // unpaired hits, then a hit dropped on a full buffer
    i_vernier = xs();
    i_tdc_front_model.drive(0, 1);
    wait_chan();
    check("lead_edge", 3'b010, cw.first[45:43] & 3'b110);
    check("vernier", i_vernier, cw.first.vernier);
    check("second_cycle_count", {1'b0, cw.first.first_cycle_count},
          cw.first.second_cycle_count);
    check("unpaired_second", 0, cw.second);
    i_tdc_front_model.drive(0, 0);
    wait_chan();
    check("trail_edge", 0, cw.first.edge_bit);
    i_chan_full = 1'b1;
    i_tdc_front_model.drive(0, 1);
    cyc(5);
    i_chan_full = 1'b0;
    i_tdc_front_model.drive(0, 0);
    wait_chan();
    check("rejected", 1, cw[`CB_REJ_FIRST]);
    // paired: lead stored, trailing found
    i_pair_mode = 1'b1;
    i_tdc_front_model.drive(0, 1);
    cyc(5);
    i_tdc_front_model.drive(0, 0);
    wait_chan();
    check("pair_edge", 0, cw.second.edge_bit);
    check("pair_reject", 0, cw[`CB_REJ_SECOND]);
    // paired: trailing edge dropped on a full buffer, next lead emits
    i_tdc_front_model.drive(0, 1);
    cyc(5);
    i_chan_full = 1'b1;
    i_tdc_front_model.drive(0, 0);
    cyc(5);
    i_chan_full = 1'b0;
    i_tdc_front_model.drive(0, 1);
    wait_chan();
    check("pair_no_trail", 1, cw.second.edge_bit);
    // level-1 word flags across the overflow thresholds
    for (int k = 0; k < 16; k++)
    begin
      @(negedge i_clk);
      {i_l1_valid, i_l1_data, i_l1_separator} = {1'b1, xs(), xs() > 32'hc0000000};
      i_l1_occupancy = occ_tab[k % 8];
      sticky = (i_l1_occupancy >= `L1_OVF_START) ? 1'b1 :
               (i_l1_occupancy < `L1_OVF_RECOVER) ? 1'b0 : sticky;
      lw = {1'b0, i_l1_separator, sticky, i_l1_occupancy >= `L1_OVF_START,
            i_l1_separator ? 32'h0 : i_l1_data};
      lw.parity = ^lw[34:0];
      @(negedge i_clk);
      i_l1_valid = 1'b0;
      check("l1_valid", 1, o_l1_valid);
      check("l1_word", lw, o_l1_word);
    end
    finish_test();
  end
endmodule : tb_tdc_align

//--- dv/tdc_front_model.sv
// stand-in for the hit discriminators and trigger distribution
// assumes the bench calls drive(); pins move on falling edges only
`timescale 1ns/10ps
module tdc_front_model (
  input  wire logic i_clk,
  output logic      o_hit,
  output logic      o_trigger,
  output logic      o_bunch_rst,
  output logic      o_event_rst
);
  // all pins idle low until the bench asks for an edge
  initial
  begin
    o_hit       = 1'b0;
    o_trigger   = 1'b0;
    o_bunch_rst = 1'b0;
    o_event_rst = 1'b0;
  end

  // levels are held by the caller long enough for the 2-ff sync
  task automatic drive(input int which, input logic lvl);
    @(negedge i_clk);
    case (which)
      0: o_hit = lvl;
      1: o_trigger = lvl;
      2: o_bunch_rst = lvl;
      default: o_event_rst = lvl;
    endcase
  endtask : drive
endmodule : tdc_front_model

//--- shared/tdc_align_pkg.sv
// types of the time alignment counters and buffer word flags
// assumes tdc_align_regs.svh supplies the numeric constants
package tdc_align_pkg;

  // one channel buffer measurement, 46 bits
  typedef struct packed {
    logic        rejected;
    logic        edge_bit;
    logic        c2_par;
    logic [12:0] second_cycle_count;
    logic        c1_par;
    logic [11:0] first_cycle_count;
    logic [16:0] vernier;
  } meas_t;

  // second measurement in bits 91:46, first in 45:0
  typedef struct packed {
    meas_t second;
    meas_t first;
  } chan_word_t;

  typedef struct packed {
    logic        parity;
    logic        separator;
    logic        buf_ovf;
    logic        ovf_start;
    logic [31:0] data;
  } l1_word_t;

  typedef struct packed {
    logic [11:0] coarse;
    logic [11:0] tag;
    logic [11:0] event_num;
    logic [11:0] reject;
  } counters_t;

  typedef struct packed {
    logic [11:0] mask_span;
    logic [11:0] search_span;
    logic [11:0] match_span;
    logic [11:0] age_pre;
    logic [11:0] event_pre;
    logic [11:0] tag_pre;
    logic [11:0] measure_pre;
    logic [11:0] wrap;
    logic [11:0] en_low;
    logic [11:0] en_high;
  } csr_t;

  typedef enum logic [0:0] {
    REC_IDLE = 1'b0,
    REC_LEAD = 1'b1
  } rec_state_t;

  typedef struct packed {
    csr_t        csr;
    counters_t   cnt;
    logic        bunch_s1;
    logic        bunch_s2;
    logic        evrst_s1;
    logic        evrst_s2;
    logic        trig_s1;
    logic        trig_s2;
    logic        trig_p;
    logic        hit_s1;
    logic        hit_s2;
    logic        hit_p;
    logic        trig_valid;
    logic [11:0] trig_tag;
    logic [11:0] trig_event;
    logic [11:0] search_left;
    logic [11:0] match_left;
    logic        search_open;
    logic        match_open;
    logic [11:0] latency;
    logic [11:0] age_limit;
    logic        reject_old;
    rec_state_t  rec;
    logic        pend_rej;
    chan_word_t  chan_word;
    logic        chan_valid;
    logic [11:0] rdata;
  } align_state_t;

  typedef struct packed {
    l1_word_t word;
    logic     valid;
    logic     sticky;
  } l1_state_t;

endpackage : tdc_align_pkg

//--- shared/tdc_align_regs.svh
// offsets, reset values, field positions and thresholds of the
// time alignment counters; assumes inclusion by bare name
`ifndef TDC_ALIGN_REGS_SVH
`define TDC_ALIGN_REGS_SVH

// register indices on the configuration port; index 0 is read-only
`define CSR_STATUS        4'h0
`define CSR_MASK_SPAN     4'h1
`define CSR_SEARCH_SPAN   4'h2
`define CSR_MATCH_SPAN    4'h3
`define CSR_AGE_PRE       4'h4
`define CSR_EVENT_PRE     4'h5
`define CSR_TAG_PRE       4'h6
`define CSR_MEASURE_PRE   4'h7
`define CSR_WRAP          4'h8
`define CSR_EN_LOW        4'hd
`define CSR_EN_HIGH       4'he

// reset values
`define RST_SPAN          12'h000
`define RST_PRELOAD       12'h000
`define RST_WRAP          12'hfff
`define RST_ENABLES       12'hfff

// level-1 buffer occupancy thresholds
`define L1_OVF_START      9'h0fd
`define L1_OVF_RECOVER    9'h0fb

// field positions
`define CB_REJ_FIRST      45
`define CB_REJ_SECOND     91
`define L1_PAR_BIT        35
`define L1_SEP_BIT        34
`define L1_BOVF_BIT       33
`define L1_OVF_BIT        32

`endif

//--- verilog/l1_word_flags.sv
// level-1 buffer word flag generation: separator, overflow, parity
// assumes data and occupancy come from logic on the same clock
`timescale 1ns/10ps
`include "tdc_align_regs.svh"
module l1_word_flags (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_valid,
  input  wire logic [31:0]             i_data,
  input  wire logic                    i_separator,
  input  wire logic [8:0]              i_occupancy,
  output tdc_align_pkg::l1_word_t      o_word,
  output logic                         o_valid
);
  import tdc_align_pkg::*;

  l1_state_t s;
  l1_state_t n;

  // sticky overflow has hysteresis between start and recover levels
  always_comb
  begin
    n = s;
    n.valid = i_valid;
    if (i_occupancy >= `L1_OVF_START)
      n.sticky = 1'b1;
    else if (i_occupancy < `L1_OVF_RECOVER)
      n.sticky = 1'b0;
    if (i_valid)
    begin
      n.word.separator = i_separator;
      n.word.data = i_separator ? 32'h0000_0000 : i_data;
      n.word.ovf_start = (i_occupancy >= `L1_OVF_START);
      n.word.buf_ovf = n.sticky;
      n.word.parity = ^n.word[34:0];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      s <= '0;
    else
      s <= n;
  end

  assign o_word = s.word;
  assign o_valid = s.valid;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  separator_zero_a: assert property (
    i_valid && i_separator |=> o_word.data == 32'h0000_0000 &&
      o_word[`L1_SEP_BIT])
    else $error("separator word carries data");
  overflow_start_a: assert property (
    i_valid |=> o_word[`L1_OVF_BIT] ==
      ($past(i_occupancy) >= 9'h0fd))
    else $error("overflow start flag wrong");
  sticky_hold_a: assert property (
    s.sticky && i_occupancy >= 9'h0fb |=> s.sticky)
    else $error("sticky overflow dropped early");
  word_parity_a: assert property (
    o_valid |-> o_word[`L1_PAR_BIT] == ^o_word[34:0])
    else $error("level-1 word parity wrong");
endmodule : l1_word_flags

//--- verilog/tdc_align.sv
// time reference counters, trigger tagging, reject age, channel word
// packing and level-1 word flags of a multi-channel tdc
// assumes pins are asynchronous; vernier, occupancy and l1 data
// come from logic on i_clk
//
// Overview of operation
// - All timing is taken on rising clock edges, coarse time counting whole cycles.
// - Bunch count reset loads every time counter with its own preload value.
// - Trigger latency equals measure preload minus trigger tag preload, modulo 4096.
// - An event whose age exceeds measure preload minus age preload, modulo 4096, is rejected.
// - Span settings are positive tick counts, 0x001 one tick up to 0xfff 4095 ticks.
// - Every counter wraps to zero after the wrap value, and larger settings act no further.
// - Each measurement carries a rejected flag, bit 45 and bit 91, for hits dropped on a full buffer.
// - The edge bit marks leading edges when unpaired, and a missing trailing edge when paired.
// - A separator word sets bit 34 and carries zero in bits 31:0.
// - A level-1 word sets bit 32 when occupancy is 253 or more.
// - The sticky overflow bit 33 holds from overflow until occupancy drops below 251.
// - Bit 35 of each level-1 word is the parity of bits 34:0.
`timescale 1ns/10ps
`include "tdc_align_regs.svh"
module tdc_align (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_csr_we,
  input  wire logic [3:0]              i_csr_addr,
  input  wire logic [11:0]             i_csr_wdata,
  input  wire logic                    i_bunch_rst,
  input  wire logic                    i_event_rst,
  input  wire logic                    i_trigger,
  input  wire logic                    i_hit,
  input  wire logic                    i_pair_mode,
  input  wire logic [16:0]             i_vernier,
  input  wire logic                    i_chan_full,
  input  wire logic                    i_oldest_valid,
  input  wire logic [11:0]             i_oldest_coarse,
  input  wire logic                    i_l1_valid,
  input  wire logic [31:0]             i_l1_data,
  input  wire logic                    i_l1_separator,
  input  wire logic [8:0]              i_l1_occupancy,
  output logic [11:0]                  o_csr_rdata,
  output logic [11:0]                  o_coarse_time,
  output logic                         o_trig_valid,
  output logic [11:0]                  o_trig_tag,
  output logic [11:0]                  o_trig_event,
  output logic                         o_search_open,
  output logic                         o_match_open,
  output logic [11:0]                  o_latency,
  output logic                         o_reject_old,
  output logic                         o_chan_valid,
  output tdc_align_pkg::chan_word_t    o_chan_word,
  output logic                         o_l1_valid,
  output tdc_align_pkg::l1_word_t      o_l1_word,
  output logic [23:0]                  o_channel_enable
);
  import tdc_align_pkg::*;

  align_state_t s;
  align_state_t n;
  logic         trig_hit;
  logic         hit_rise;
  logic         hit_fall;
  logic [11:0]  age;

  // step with wrap to zero once the wrap value is reached
  function automatic logic [11:0] bump(input logic [11:0] v,
                                       input logic [11:0] wrap);
    bump = (v >= wrap) ? 12'h000 : 12'(v + 12'h001);
  endfunction : bump

  // settings beyond the wrap value behave as the wrap value
  function automatic logic [11:0] clamp(input logic [11:0] v,
                                        input logic [11:0] wrap);
    clamp = (v > wrap) ? wrap : v;
  endfunction : clamp

  // one measurement built from the live coarse count
  function automatic meas_t take(input logic [11:0] c,
                                 input logic [16:0] vern,
                                 input logic        rej,
                                 input logic        edge_bit);
    meas_t m;
    m.rejected = rej;
    m.edge_bit = edge_bit;
    m.first_cycle_count = c;
    m.second_cycle_count = {1'b0, c};
    m.c1_par = ^c;
    m.c2_par = ^m.second_cycle_count;
    m.vernier = vern;
    take = m;
  endfunction : take

  // edge detects look only at second synchroniser stages
  assign trig_hit = s.trig_s2 & ~s.trig_p;
  assign hit_rise = s.hit_s2 & ~s.hit_p;
  assign hit_fall = ~s.hit_s2 & s.hit_p;
  assign age = 12'(s.cnt.coarse - i_oldest_coarse);

  always_comb
  begin
    n = s;
    // two-stage synchronisers for pin inputs
    n.bunch_s1 = i_bunch_rst;
    n.bunch_s2 = s.bunch_s1;
    n.evrst_s1 = i_event_rst;
    n.evrst_s2 = s.evrst_s1;
    n.trig_s1 = i_trigger;
    n.trig_s2 = s.trig_s1;
    n.trig_p = s.trig_s2;
    n.hit_s1 = i_hit;
    n.hit_s2 = s.hit_s1;
    n.hit_p = s.hit_s2;

    // time counters, all twelve bits, loaded at time zero
    if (s.bunch_s2)
    begin
      n.cnt.coarse = clamp(s.csr.measure_pre, s.csr.wrap);
      n.cnt.tag = clamp(s.csr.tag_pre, s.csr.wrap);
      n.cnt.reject = clamp(s.csr.age_pre, s.csr.wrap);
    end
    else
    begin
      n.cnt.coarse = bump(s.cnt.coarse, s.csr.wrap);
      n.cnt.tag = bump(s.cnt.tag, s.csr.wrap);
      n.cnt.reject = bump(s.cnt.reject, s.csr.wrap);
    end
    // event number also restarts on the event reset pin
    if (s.bunch_s2 || s.evrst_s2)
      n.cnt.event_num = clamp(s.csr.event_pre, s.csr.wrap);
    else if (trig_hit)
      n.cnt.event_num = bump(s.cnt.event_num, s.csr.wrap);

    // the tag lags coarse time by the latency, so it names the hits
    n.trig_valid = trig_hit;
    if (trig_hit)
    begin
      n.trig_tag = s.cnt.tag;
      n.trig_event = s.cnt.event_num;
    end
    n.latency = 12'(s.csr.measure_pre - s.csr.tag_pre);
    n.age_limit = 12'(s.csr.measure_pre - s.csr.age_pre);
    n.reject_old = i_oldest_valid && (age > s.age_limit);

    // windows open for a whole positive number of ticks
    if (trig_hit)
    begin
      n.search_left = clamp(s.csr.search_span, s.csr.wrap);
      n.match_left = clamp(s.csr.match_span, s.csr.wrap);
    end
    else
    begin
      if (s.search_left != 12'h000)
        n.search_left = 12'(s.search_left - 12'h001);
      if (s.match_left != 12'h000)
        n.match_left = 12'(s.match_left - 12'h001);
    end
    n.search_open = (n.search_left != 12'h000);
    n.match_open = (n.match_left != 12'h000);

    // channel buffer packing; a full buffer drops the hit and flags
    // the next stored measurement, whose time is then not the hit's
    n.chan_valid = 1'b0;
    if ((hit_rise || hit_fall) && i_chan_full)
      n.pend_rej = 1'b1;
    else if (!i_pair_mode)
    begin
      if (hit_rise || hit_fall)
      begin
        n.chan_word.first = take(s.cnt.coarse, i_vernier, s.pend_rej,
                                 hit_rise);
        n.chan_word.second = '0;
        n.chan_valid = 1'b1;
        n.pend_rej = 1'b0;
        n.rec = REC_IDLE;
      end
    end
    else
    begin
      case (s.rec)
        REC_IDLE:
        begin
          if (hit_rise)
          begin
            n.chan_word.first = take(s.cnt.coarse, i_vernier,
                                     s.pend_rej, 1'b1);
            n.pend_rej = 1'b0;
            n.rec = REC_LEAD;
          end
        end
        REC_LEAD:
        begin
          if (hit_fall)
          begin
            n.chan_word.second = take(s.cnt.coarse, i_vernier,
                                      s.pend_rej, 1'b0);
            n.pend_rej = 1'b0;
            n.chan_valid = 1'b1;
            n.rec = REC_IDLE;
          end
          else if (hit_rise)
          begin
            // no trailing edge seen: emit with edge set, drop new lead, go idle
            n.chan_word.second = '0;
            n.chan_word.second.edge_bit = 1'b1;
            n.chan_valid = 1'b1;
            n.rec = REC_IDLE;
          end
        end
        default: n.rec = REC_IDLE;
      endcase
    end

    // configuration writes; counters pick up new preloads at time zero
    if (i_csr_we)
    begin
      if (i_csr_addr == `CSR_MASK_SPAN)
        n.csr.mask_span = i_csr_wdata;
      else if (i_csr_addr == `CSR_SEARCH_SPAN)
        n.csr.search_span = i_csr_wdata;
      else if (i_csr_addr == `CSR_MATCH_SPAN)
        n.csr.match_span = i_csr_wdata;
      else if (i_csr_addr == `CSR_AGE_PRE)
        n.csr.age_pre = i_csr_wdata;
      else if (i_csr_addr == `CSR_EVENT_PRE)
        n.csr.event_pre = i_csr_wdata;
      else if (i_csr_addr == `CSR_TAG_PRE)
        n.csr.tag_pre = i_csr_wdata;
      else if (i_csr_addr == `CSR_MEASURE_PRE)
        n.csr.measure_pre = i_csr_wdata;
      else if (i_csr_addr == `CSR_WRAP)
        n.csr.wrap = i_csr_wdata;
      else if (i_csr_addr == `CSR_EN_LOW)
        n.csr.en_low = i_csr_wdata;
      else if (i_csr_addr == `CSR_EN_HIGH)
        n.csr.en_high = i_csr_wdata;
    end

    // read-back; index 0 shows live coarse time, unmapped reads zero
    if (i_csr_addr == `CSR_STATUS)
      n.rdata = s.cnt.coarse;
    else if (i_csr_addr == `CSR_MASK_SPAN)
      n.rdata = s.csr.mask_span;
    else if (i_csr_addr == `CSR_SEARCH_SPAN)
      n.rdata = s.csr.search_span;
    else if (i_csr_addr == `CSR_MATCH_SPAN)
      n.rdata = s.csr.match_span;
    else if (i_csr_addr == `CSR_AGE_PRE)
      n.rdata = s.csr.age_pre;
    else if (i_csr_addr == `CSR_EVENT_PRE)
      n.rdata = s.csr.event_pre;
    else if (i_csr_addr == `CSR_TAG_PRE)
      n.rdata = s.csr.tag_pre;
    else if (i_csr_addr == `CSR_MEASURE_PRE)
      n.rdata = s.csr.measure_pre;
    else if (i_csr_addr == `CSR_WRAP)
      n.rdata = s.csr.wrap;
    else if (i_csr_addr == `CSR_EN_LOW)
      n.rdata = s.csr.en_low;
    else if (i_csr_addr == `CSR_EN_HIGH)
      n.rdata = s.csr.en_high;
    else
      n.rdata = 12'h000;
  end

  // all state in one register; reset values are constants only
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s <= '0;
      s.csr.mask_span <= `RST_SPAN;
      s.csr.search_span <= `RST_SPAN;
      s.csr.match_span <= `RST_SPAN;
      s.csr.age_pre <= `RST_PRELOAD;
      s.csr.event_pre <= `RST_PRELOAD;
      s.csr.tag_pre <= `RST_PRELOAD;
      s.csr.measure_pre <= `RST_PRELOAD;
      s.csr.wrap <= `RST_WRAP;
      s.csr.en_low <= `RST_ENABLES;
      s.csr.en_high <= `RST_ENABLES;
      s.rec <= REC_IDLE;
    end
    else
      s <= n;
  end

  l1_word_flags u_l1_flags (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_valid     (i_l1_valid),
    .i_data      (i_l1_data),
    .i_separator (i_l1_separator),
    .i_occupancy (i_l1_occupancy),
    .o_word      (o_l1_word),
    .o_valid     (o_l1_valid)
  );

  assign o_csr_rdata = s.rdata;
  assign o_coarse_time = s.cnt.coarse;
  assign o_trig_valid = s.trig_valid;
  assign o_trig_tag = s.trig_tag;
  assign o_trig_event = s.trig_event;
  assign o_search_open = s.search_open;
  assign o_match_open = s.match_open;
  assign o_latency = s.latency;
  assign o_reject_old = s.reject_old;
  assign o_chan_valid = s.chan_valid;
  assign o_chan_word = s.chan_word;
  assign o_channel_enable = {s.csr.en_high, s.csr.en_low};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  coarse_step_a: assert property (
    !s.bunch_s2 && s.cnt.coarse < s.csr.wrap |=>
      s.cnt.coarse == 12'($past(s.cnt.coarse) + 12'h001))
    else $error("coarse time missed a cycle");
  preload_load_a: assert property (
    s.bunch_s2 && s.csr.tag_pre <= s.csr.wrap |=>
      s.cnt.tag == $past(s.csr.tag_pre))
    else $error("tag counter not preloaded");
  latency_diff_a: assert property (
    !i_csr_we ##1 !i_csr_we |=> o_latency ==
      12'($past(s.csr.measure_pre, 2) - $past(s.csr.tag_pre, 2)))
    else $error("latency differs from preload difference");
  reject_age_a: assert property (
    i_oldest_valid && age > s.age_limit |=> o_reject_old)
    else $error("old event not rejected");
  search_len_a: assert property (
    trig_hit && s.csr.search_span == 12'h001 |=>
      o_search_open ##1 !o_search_open)
    else $error("one tick window wrong length");
  wrap_zero_a: assert property (
    !s.bunch_s2 && s.cnt.coarse >= s.csr.wrap |=>
      s.cnt.coarse == 12'h000)
    else $error("coarse time did not wrap");
  rejected_flag_a: assert property (
    o_chan_valid && !i_pair_mode && $past(s.pend_rej) |->
      o_chan_word[`CB_REJ_FIRST])
    else $error("dropped hit not flagged");
  edge_unpaired_a: assert property (
    o_chan_valid && $past(!i_pair_mode) |->
      o_chan_word.first.edge_bit == $past(s.hit_s2))
    else $error("unpaired edge bit wrong");
endmodule : tdc_align
